// *** rtl/qpfe_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "qpfe_cfg.svh"

module qpfe_core
  import qpfe_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        external_reset_n,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic [10:0]      pm_addr,
  input  wire logic [11:0] pm_data,
  output logic [6:0]       df_addr,
  output logic             df_rd_en,
  input  wire logic [7:0]  df_rdata,
  output logic             df_wr_en,
  output logic [7:0]       df_wdata,
  output logic             quarter_phase_one,
  output logic             quarter_phase_two,
  output logic             quarter_phase_three,
  output logic             quarter_phase_four,
  output logic             cycle_rate_output
);

  // ****************************************
  // state
  // ****************************************
  logic        core_rst;
  qpfe_phase_t phase;
  logic [2:0]  ctrl_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [10:0] ip_q;
  logic [10:0] pm_addr_q;
  logic [11:0] ir_q;
  logic        ir_valid_q;
  logic [7:0]  acc_q;
  logic [7:0]  stat_q;
  logic [7:0]  ptr_q;
  logic [7:0]  opnd_q;
  logic [6:0]  df_addr_q;
  logic        df_rd_en_q;
  logic        df_wr_en_q;
  logic [7:0]  df_wdata_q;
  logic        cyc_out_q;

  // ****************************************
  // decode wires
  // ****************************************
  logic [10:0] ip_mask_w;
  logic        ex_w;
  qpfe_cls_t   cls_w;
  logic [4:0]  f_w;
  logic [4:0]  fa_w;
  logic [6:0]  ext_addr_w;
  logic        int_w;
  logic        rd_file_w;
  logic        wr_file_w;
  logic        wr_acc_w;
  logic        goto_w;
  logic        ipl_wr_w;
  logic [7:0]  bit_mask_w;
  logic [7:0]  bit_res_w;
  logic [7:0]  wv_w;
  logic [7:0]  int_rd_w;
  logic        bus_req_w;
  logic [31:0] rd_mux_w;

  qpfe_alu_if alu_bus ();

  assign core_rst = sys_rst | ~external_reset_n;

  // ****************************************
  // phase generator and arithmetic unit
  // ****************************************
  // divide by four
  qpfe_phase u_phase (
    .clk     (clk),
    .rst     (core_rst),
    .phase_q (phase)
  );

  qpfe_alu u_alu (
    .bus (alu_bus.alu)
  );

  // phase outputs come straight from the one-hot phase flops
  assign quarter_phase_one   = phase[0];
  assign quarter_phase_two   = phase[1];
  assign quarter_phase_three = phase[2];
  assign quarter_phase_four  = phase[3];

  // ****************************************
  // program size and decode
  // ****************************************
  // size select masks the pointer
  always_comb begin
    case (ctrl_q[2:1])
      `QPFE_SZ_512: ip_mask_w = `QPFE_MASK_512;
      `QPFE_SZ_1K:  ip_mask_w = `QPFE_MASK_1K;
      default:      ip_mask_w = `QPFE_MASK_2K;
    endcase
  end

  // the held word is stable from the end of phase four until the next one
  assign ex_w  = ir_valid_q;
  assign cls_w = qpfe_cls_t'(ir_q[11:10]);
  assign f_w   = ir_q[4:0];

  // indirect slot goes through the pointer
  assign fa_w = (f_w == `QPFE_FA_IND) ? ptr_q[4:0] : f_w;

  // upper file half banked by pointer
  assign ext_addr_w = (f_w == `QPFE_FA_IND) ? ptr_q[6:0] :
                      (f_w >= `QPFE_BANK_BASE) ? {ptr_q[6:5], f_w} : {2'b00, f_w};

  // special registers live in file space
  assign int_w = (fa_w == `QPFE_FA_IND) | (fa_w == `QPFE_FA_IPL) |
                 (fa_w == `QPFE_FA_STAT) | (fa_w == `QPFE_FA_PTR);

  assign rd_file_w = ex_w & ((cls_w == qpfe_cls_file) | (cls_w == qpfe_cls_bit));
  assign wr_file_w = ex_w & (((cls_w == qpfe_cls_file) & (ir_q[9:7] != 3'h7) &
                     (ir_q[5] | (ir_q[9:6] == qpfe_alu_movw))) | (cls_w == qpfe_cls_bit));
  // accumulator written by destination bit or a literal, never by a no-op
  assign wr_acc_w  = ex_w & (((cls_w == qpfe_cls_file) & ~ir_q[5] & (ir_q[9:7] != 3'h7) &
                     (ir_q[9:6] != qpfe_alu_movw)) | (cls_w == qpfe_cls_lit));
  assign goto_w    = ex_w & (cls_w == qpfe_cls_goto);
  assign ipl_wr_w  = wr_file_w & (fa_w == `QPFE_FA_IPL);

  // single-bit set or clear on the operand
  assign bit_mask_w = 8'h01 << ir_q[7:5];
  assign bit_res_w  = ir_q[9] ? (opnd_q | bit_mask_w) : (opnd_q & ~bit_mask_w);
  assign wv_w       = (cls_w == qpfe_cls_bit) ? bit_res_w : alu_bus.res;

  // ****************************************
  // arithmetic unit inputs
  // ****************************************
  // accumulator with file or literal
  assign alu_bus.acc  = acc_q;
  assign alu_bus.opnd = (cls_w == qpfe_cls_lit) ? ir_q[7:0] : opnd_q;
  assign alu_bus.cin  = stat_q[`QPFE_ST_C];
  always_comb begin
    case (cls_w)
      qpfe_cls_file: alu_bus.op = qpfe_alu_op_t'(ir_q[9:6]);
      qpfe_cls_lit: begin
        case (ir_q[9:8])
          2'h1:    alu_bus.op = qpfe_alu_and;
          2'h2:    alu_bus.op = qpfe_alu_or;
          2'h3:    alu_bus.op = qpfe_alu_xor;
          default: alu_bus.op = qpfe_alu_ld;
        endcase
      end
      default: alu_bus.op = qpfe_alu_ld; // jumps and bit ops leave flags alone
    endcase
  end

  // special registers are read inside the core, every other file address from the data file
  always_comb begin
    case (fa_w)
      `QPFE_FA_IPL:  int_rd_w = ip_q[7:0];
      `QPFE_FA_STAT: int_rd_w = stat_q;
      `QPFE_FA_PTR:  int_rd_w = ptr_q;
      `QPFE_FA_IND:  int_rd_w = 8'h00; // pointer to itself reads zero
      default:       int_rd_w = df_rdata;
    endcase
  end

  // ****************************************
  // fetch side
  // ****************************************
  // advance at phase one
  always_ff @(posedge clk) begin
    if (core_rst) begin
      ip_q <= ip_mask_w; // top word first, so a no-op there wraps to zero
    end else if (phase == qpfe_ph1) begin
      ip_q <= 11'(ip_q + 11'h001) & ip_mask_w;
    end else if ((phase == qpfe_ph4) && goto_w) begin
      ip_q <= {stat_q[6:5], ir_q[8:0]} & ip_mask_w;
    end else if ((phase == qpfe_ph4) && ipl_wr_w) begin
      ip_q <= {stat_q[6:5], 1'b0, wv_w} & ip_mask_w;
    end
  end

  // address held phase two to four
  always_ff @(posedge clk) begin
    if (core_rst) begin
      pm_addr_q <= 11'h000;
    end else if (phase == qpfe_ph1) begin
      pm_addr_q <= ip_q;
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      ir_q       <= 12'h000;
      ir_valid_q <= 1'b0;
    end else if (phase == qpfe_ph4) begin
      ir_q       <= pm_data;
      ir_valid_q <= ~(goto_w | ipl_wr_w);
    end
  end

  // ****************************************
  // execute side
  // ****************************************
  // read strobe during phase two
  always_ff @(posedge clk) begin
    if (core_rst) begin
      df_addr_q  <= 7'h00;
      df_rd_en_q <= 1'b0;
    end else if (phase == qpfe_ph1) begin
      df_addr_q  <= ext_addr_w;
      df_rd_en_q <= rd_file_w & ~int_w;
    end else if (phase == qpfe_ph2) begin
      df_rd_en_q <= 1'b0;
    end
  end

  // operand captured end of phase two
  always_ff @(posedge clk) begin
    if (core_rst) begin
      opnd_q <= 8'h00;
    end else if (phase == qpfe_ph2) begin
      opnd_q <= int_rd_w;
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      df_wr_en_q <= 1'b0;
      df_wdata_q <= 8'h00;
    end else if (phase == qpfe_ph3) begin
      df_wr_en_q <= wr_file_w & ~int_w;
      df_wdata_q <= wv_w;
    end else if (phase == qpfe_ph4) begin
      df_wr_en_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      acc_q <= 8'h00;
    end else if ((phase == qpfe_ph4) && wr_acc_w) begin
      acc_q <= alu_bus.res;
    end
  end

  // pointer register written from file space
  always_ff @(posedge clk) begin
    if (core_rst) begin
      ptr_q <= `QPFE_PTR_RST;
    end else if ((phase == qpfe_ph4) && wr_file_w && (fa_w == `QPFE_FA_PTR)) begin
      ptr_q <= wv_w;
    end
  end

  // flags win over a direct write
  always_ff @(posedge clk) begin
    if (core_rst) begin
      stat_q <= `QPFE_ST_RST;
    end else if ((phase == qpfe_ph4) && ex_w) begin
      if (wr_file_w && (fa_w == `QPFE_FA_STAT)) begin
        stat_q[7:5] <= wv_w[7:5];
        stat_q[2:0] <= wv_w[2:0];
      end
      if (alu_bus.upd_c) begin
        stat_q[`QPFE_ST_C] <= alu_bus.cout;
      end
      if (alu_bus.upd_nc) begin
        stat_q[`QPFE_ST_NC] <= alu_bus.dcout;
      end
      if (alu_bus.upd_z) begin
        stat_q[`QPFE_ST_Z] <= alu_bus.zout;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      cyc_out_q <= 1'b0;
    end else if (phase == qpfe_ph2) begin
      cyc_out_q <= ctrl_q[`QPFE_CTRL_RC];
    end else if (phase == qpfe_ph4) begin
      cyc_out_q <= 1'b0;
    end
  end

  // ****************************************
  // bus slave
  // ****************************************
  // one wait state: ack comes the edge after the request is seen
  assign bus_req_w = wb_cyc_i & wb_stb_i & ~ack_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req_w;
    end
  end

  // control register survives the reset pin, so mode holds across it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= `QPFE_CTRL_RST;
    end else if (bus_req_w && wb_we_i && wb_sel_i[0] && (wb_adr_i == `QPFE_OFS_CTRL)) begin
      ctrl_q <= wb_dat_i[2:0];
    end
  end

  // unmapped offsets read zero and ignore writes
  always_comb begin
    case (wb_adr_i)
      `QPFE_OFS_CTRL: rd_mux_w = {29'h0, ctrl_q};
      `QPFE_OFS_IP:   rd_mux_w = {21'h0, ip_q};
      `QPFE_OFS_STAT: rd_mux_w = {8'h00, ptr_q, stat_q, acc_q};
      `QPFE_OFS_IR:   rd_mux_w = {19'h0, ir_valid_q, ir_q};
      default:        rd_mux_w = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdat_q <= 32'h0000_0000;
    end else if (bus_req_w && !wb_we_i) begin
      rdat_q <= rd_mux_w;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wb_ack_o          = ack_q;
  assign wb_dat_o          = rdat_q;
  assign pm_addr           = pm_addr_q;
  assign df_addr           = df_addr_q;
  assign df_rd_en          = df_rd_en_q;
  assign df_wr_en          = df_wr_en_q;
  assign df_wdata          = df_wdata_q;
  assign cycle_rate_output = cyc_out_q;

endmodule // qpfe_core

`default_nettype wire

// *** rtl/qpfe_cfg.svh ***
`ifndef QPFE_CFG_SVH
`define QPFE_CFG_SVH

// ****************************************
// widths
// ****************************************
`define QPFE_IW          12
`define QPFE_DW          8
`define QPFE_PW          11
`define QPFE_FAW         7

// ****************************************
// bus register offsets and reset values
// ****************************************
`define QPFE_OFS_CTRL    8'h00
`define QPFE_OFS_IP      8'h04
`define QPFE_OFS_STAT    8'h08
`define QPFE_OFS_IR      8'h0c
`define QPFE_CTRL_RST    3'h5
`define QPFE_CTRL_RC     0
`define QPFE_SZ_512      2'h0
`define QPFE_SZ_1K       2'h1
`define QPFE_MASK_512    11'h1ff
`define QPFE_MASK_1K     11'h3ff
`define QPFE_MASK_2K     11'h7ff

// ****************************************
// status layout, file map, reset values
// ****************************************
`define QPFE_ST_C        0
`define QPFE_ST_NC       1
`define QPFE_ST_Z        2
`define QPFE_ST_RST      8'h18
`define QPFE_PTR_RST     8'h80
`define QPFE_FA_IND      5'h00
`define QPFE_FA_IPL      5'h02
`define QPFE_FA_STAT     5'h03
`define QPFE_FA_PTR      5'h04
`define QPFE_BANK_BASE   5'h10

`endif

// *** rtl/qpfe_pkg.sv ***
`default_nettype none

package qpfe_pkg;

  // one-hot quarter phase of the instruction cycle
  typedef enum logic [3:0] {
    qpfe_ph1 = 4'h1,
    qpfe_ph2 = 4'h2,
    qpfe_ph3 = 4'h4,
    qpfe_ph4 = 4'h8
  } qpfe_phase_t;

  // instruction class in bits 11:10
  typedef enum logic [1:0] {
    qpfe_cls_file = 2'h0,
    qpfe_cls_lit  = 2'h1,
    qpfe_cls_goto = 2'h2,
    qpfe_cls_bit  = 2'h3
  } qpfe_cls_t;

  // arithmetic unit operations, file class bits 9:6
  typedef enum logic [3:0] {
    qpfe_alu_mov  = 4'h0,
    qpfe_alu_add  = 4'h1,
    qpfe_alu_sub  = 4'h2,
    qpfe_alu_and  = 4'h3,
    qpfe_alu_or   = 4'h4,
    qpfe_alu_xor  = 4'h5,
    qpfe_alu_com  = 4'h6,
    qpfe_alu_inc  = 4'h7,
    qpfe_alu_dec  = 4'h8,
    qpfe_alu_rl   = 4'h9,
    qpfe_alu_rr   = 4'ha,
    qpfe_alu_swap = 4'hb,
    qpfe_alu_clr  = 4'hc,
    qpfe_alu_movw = 4'hd,
    qpfe_alu_ld   = 4'he,
    qpfe_alu_nop  = 4'hf
  } qpfe_alu_op_t;

endpackage

`default_nettype wire

// *** rtl/qpfe_alu_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface qpfe_alu_if;
  import qpfe_pkg::*;
  logic [7:0]   acc;
  logic [7:0]   opnd;
  logic         cin;
  qpfe_alu_op_t op;
  logic [7:0]   res;
  logic         cout;
  logic         dcout;
  logic         zout;
  logic         upd_c;
  logic         upd_nc;
  logic         upd_z;
  modport core (output acc, opnd, cin, op, input res, cout, dcout, zout, upd_c, upd_nc, upd_z);
  modport alu  (input acc, opnd, cin, op, output res, cout, dcout, zout, upd_c, upd_nc, upd_z);
endinterface

`default_nettype wire

// *** rtl/qpfe_phase.sv ***
`timescale 1ns/1ps
`default_nettype none

module qpfe_phase
  import qpfe_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  output qpfe_phase_t phase_q
);

  // ****************************************
  // divide by four, restart at phase one
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= qpfe_ph1;
    end else begin
      case (phase_q)
        qpfe_ph1: phase_q <= qpfe_ph2;
        qpfe_ph2: phase_q <= qpfe_ph3;
        qpfe_ph3: phase_q <= qpfe_ph4;
        qpfe_ph4: phase_q <= qpfe_ph1;
        default:  phase_q <= qpfe_ph1; // recover from a bad code
      endcase
    end
  end

endmodule // qpfe_phase

`default_nettype wire

// *** rtl/qpfe_alu.sv ***
`timescale 1ns/1ps
`default_nettype none

module qpfe_alu
  import qpfe_pkg::*;
(
  qpfe_alu_if.alu bus
);

  logic       sub_w;
  logic [7:0] addend_w;
  logic [8:0] sum_w;
  logic [4:0] nib_w;

  // subtract adds the inverted accumulator plus one
  assign sub_w    = (bus.op == qpfe_alu_sub);
  assign addend_w = sub_w ? ~bus.acc : bus.acc;
  assign sum_w    = {1'b0, bus.opnd} + {1'b0, addend_w} + {8'h00, sub_w};
  assign nib_w    = {1'b0, bus.opnd[3:0]} + {1'b0, addend_w[3:0]} + {4'h0, sub_w};

  // result and flag enables per operation
  always_comb begin
    bus.res    = bus.opnd;
    bus.cout   = sum_w[8];
    bus.dcout  = nib_w[4];
    bus.upd_c  = 1'b0;
    bus.upd_nc = 1'b0;
    bus.upd_z  = 1'b1;
    case (bus.op)
      qpfe_alu_add, qpfe_alu_sub: begin
        // carries of a subtract come out as inverted borrows
        bus.res    = sum_w[7:0];
        bus.upd_c  = 1'b1;
        bus.upd_nc = 1'b1;
      end
      qpfe_alu_and:  bus.res = bus.opnd & bus.acc;
      qpfe_alu_or:   bus.res = bus.opnd | bus.acc;
      qpfe_alu_xor:  bus.res = bus.opnd ^ bus.acc;
      qpfe_alu_com:  bus.res = ~bus.opnd;
      qpfe_alu_inc:  bus.res = 8'(bus.opnd + 8'h01);
      qpfe_alu_dec:  bus.res = 8'(bus.opnd - 8'h01);
      qpfe_alu_clr:  bus.res = 8'h00;
      qpfe_alu_rl: begin
        bus.res   = {bus.opnd[6:0], bus.cin};
        bus.cout  = bus.opnd[7];
        bus.upd_c = 1'b1;
        bus.upd_z = 1'b0;
      end
      qpfe_alu_rr: begin
        bus.res   = {bus.cin, bus.opnd[7:1]};
        bus.cout  = bus.opnd[0];
        bus.upd_c = 1'b1;
        bus.upd_z = 1'b0;
      end
      qpfe_alu_swap: begin
        bus.res   = {bus.opnd[3:0], bus.opnd[7:4]};
        bus.upd_z = 1'b0;
      end
      qpfe_alu_movw: begin
        bus.res   = bus.acc;
        bus.upd_z = 1'b0;
      end
      qpfe_alu_mov:  bus.res = bus.opnd;
      default:       bus.upd_z = 1'b0; // load and nop leave flags alone
    endcase
    bus.zout = (bus.res == 8'h00);
  end

endmodule // qpfe_alu

`default_nettype wire

// *** test/qpfe_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****
// program store and data file partner
// ****
module qpfe_mem_model (
  input  wire logic        clk,
  input  wire logic [10:0] pm_addr,
  output logic [11:0]      pm_data,
  input  wire logic [6:0]  df_addr,
  input  wire logic        df_rd_en,
  input  wire logic        df_wr_en,
  input  wire logic [7:0]  df_wdata,
  output logic [7:0]       df_rdata
);
  logic [11:0] pm [0:2047];
  logic [7:0]  df [0:127];

  // no-operation fill, so stray fetches stay harmless
  initial begin
    foreach (pm[i]) pm[i] = 12'h3c0;
    foreach (df[i]) df[i] = 8'h00;
  end

  // whole word from its own bus
  assign pm_data = pm[pm_addr];

  // idle read bus shows inverted data, stale values must not be trusted
  assign df_rdata = df_rd_en ? df[df_addr] : ~df[df_addr];

  // write lands on edge ending phase four
  always @(posedge clk) begin
    if (df_wr_en) begin
      df[df_addr] <= df_wdata;
    end
  end
endmodule // qpfe_mem_model

`default_nettype wire

// *** test/qpfe_core_props.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****
// port checker
// ****
module qpfe_core_props (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        external_reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [10:0] pm_addr,
  input wire logic [6:0]  df_addr,
  input wire logic        df_rd_en,
  input wire logic        df_wr_en,
  input wire logic        quarter_phase_one,
  input wire logic        quarter_phase_two,
  input wire logic        quarter_phase_three,
  input wire logic        quarter_phase_four,
  input wire logic        cycle_rate_output
);
  logic [3:0] ph;

  // phases gathered for compact comparisons
  assign ph = {quarter_phase_four, quarter_phase_three, quarter_phase_two, quarter_phase_one};

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !external_reset_n);

  // multi-step behaviours
  sequence s_cycle;
    ph == 4'h2 ##1 ph == 4'h4 ##1 ph == 4'h8 ##1 ph == 4'h1;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_phase_onehot; $onehot(ph); endproperty
  a_phase_onehot: assert property (p_phase_onehot) else $error("phase not one-hot");
  property p_phase_order; ph == 4'h1 |=> s_cycle; endproperty
  a_phase_order: assert property (p_phase_order) else $error("phase order broken");
  property p_fetch_hold; $changed(pm_addr) |-> $past(quarter_phase_one); endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch address moved");
  property p_rd_phase; df_rd_en |-> quarter_phase_two; endproperty
  a_rd_phase: assert property (p_rd_phase) else $error("read strobe off phase two");
  property p_wr_phase; df_wr_en |-> quarter_phase_four && $stable(df_addr); endproperty
  a_wr_phase: assert property (p_wr_phase) else $error("write strobe misplaced");
  property p_internal;
    (df_rd_en || df_wr_en) |-> !(df_addr inside {7'h00, 7'h02, 7'h03, 7'h04});
  endproperty
  a_internal: assert property (p_internal) else $error("strobe on internal address");
  property p_rate; cycle_rate_output |-> ph inside {4'h4, 4'h8}; endproperty
  a_rate: assert property (p_rate) else $error("cycle rate output off phase");
  property p_ack;
    disable iff (sys_rst) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> s_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer late or long");
  property p_ack_cause; disable iff (sys_rst) wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  property p_ext_hold;
    disable iff (sys_rst) !external_reset_n |=>
      quarter_phase_one && !df_rd_en && !df_wr_en && pm_addr == 11'h000;
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("core not held in reset");
  property p_restart;
    disable iff (sys_rst) $rose(external_reset_n) |-> quarter_phase_one ##1 quarter_phase_two;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart at phase one");
endmodule // qpfe_core_props

bind qpfe_core qpfe_core_props i_qpfe_core_props (
  .clk, .sys_rst, .external_reset_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pm_addr, .df_addr,
  .df_rd_en, .df_wr_en, .quarter_phase_one, .quarter_phase_two, .quarter_phase_three,
  .quarter_phase_four, .cycle_rate_output
);

`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        clk              = 1'b0;
  logic        sys_rst          = 1'b1;
  logic        external_reset_n = 1'b1;
  logic [7:0]  wb_adr_i         = 8'h00;
  logic [31:0] wb_dat_i         = 32'h0;
  logic [3:0]  wb_sel_i         = 4'h0;
  logic        wb_we_i          = 1'b0;
  logic        wb_cyc_i         = 1'b0;
  logic        wb_stb_i         = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [10:0] pm_addr;
  logic [11:0] pm_data;
  logic [6:0]  df_addr;
  logic        df_rd_en, df_wr_en;
  logic [7:0]  df_rdata, df_wdata;
  logic        quarter_phase_one, quarter_phase_two, quarter_phase_three, quarter_phase_four;
  logic        cycle_rate_output;
  int          num_errors      = 0;
  int          samples_checked = 0;
  logic [10:0] fetch_q [$];

  // ****
  // clock, design, partner, fetch log
  // ****
  always #12.5 clk = ~clk;

  qpfe_core i_qpfe_core (
    .clk, .sys_rst, .external_reset_n, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .pm_addr, .pm_data, .df_addr, .df_rd_en, .df_rdata,
    .df_wr_en, .df_wdata, .quarter_phase_one, .quarter_phase_two, .quarter_phase_three,
    .quarter_phase_four, .cycle_rate_output
  );

  qpfe_mem_model i_qpfe_mem_model (
    .clk, .pm_addr, .pm_data, .df_addr, .df_rd_en, .df_wr_en, .df_wdata, .df_rdata
  );

  // fetch address is steady in phase two
  always @(posedge clk) begin
    if (quarter_phase_two === 1'b1) begin
      fetch_q.push_back(pm_addr);
    end
  end

  // ****
  // shared tasks
  // ****
  task results();
    $display("compared %0d, mismatched %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // one classic cycle, entered just after a rising edge
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: bus never answered", $time);
      results();
    end
    @(posedge clk);
  endtask

  // ****
  // scenarios
  // ****
  task t_prog();
    logic [31:0] q;
    logic [10:0] exp [10];
    exp = '{11'h7ff, 11'h0, 11'h1, 11'h2, 11'h3, 11'h4, 11'h5, 11'h10, 11'h11, 11'h10};
    repeat (60) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      chk({21'h0, fetch_q[i]}, {21'h0, exp[i]}, "fetch");
    end
    chk({24'h0, i_qpfe_mem_model.df[8]}, 32'hb8, "file result");
    wb(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h0080_1a90, "acc and flags");
  endtask

  task t_phases(input logic rc);
    int n;
    n = 0;
    while (quarter_phase_one !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    for (int i = 0; i < 8; i++) begin
      chk({27'h0, cycle_rate_output, quarter_phase_four, quarter_phase_three,
           quarter_phase_two, quarter_phase_one},
          {27'h0, rc && (i % 4 >= 2), 4'h1 << (i % 4)}, "phase");
      @(posedge clk);
    end
  endtask

  task t_bus();
    logic [31:0] q;
    wb(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h5, "ctrl reset");
    wb(1'b1, 8'h40, 32'hffff_ffff, q);
    wb(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0, "unmapped");
    // rate output off outside rc mode
    wb(1'b1, 8'h00, 32'h4, q);
    t_phases(1'b0);
  endtask

  task t_ext_reset();
    logic [31:0] q;
    wb(1'b1, 8'h00, 32'h1, q);
    external_reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk({21'h0, pm_addr}, 32'h0, "held address");
    fetch_q.delete();
    external_reset_n <= 1'b1;
    repeat (12) @(posedge clk);
    chk({21'h0, fetch_q[0]}, 32'h1ff, "restart");
    chk({21'h0, fetch_q[1]}, 32'h0, "wrap");
    wb(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h1, "ctrl kept");
  endtask

  // indirect, banked, rotate, swap, bit set on page bit, paged jump
  task t_ops();
    logic [31:0] q;
    logic [11:0] prog [9];
    prog = '{12'h425, 12'h364, 12'h45a, 12'h360, 12'h371, 12'h271, 12'h2d1, 12'hea3,
             12'h810};
    wb(1'b1, 8'h00, 32'h5, q);
    external_reset_n <= 1'b0;
    foreach (prog[i]) i_qpfe_mem_model.pm[i] = prog[i];
    i_qpfe_mem_model.pm[11'h210] = 12'h810;
    repeat (2) @(posedge clk);
    fetch_q.delete();
    external_reset_n <= 1'b1;
    repeat (60) @(posedge clk);
    chk({21'h0, fetch_q[11]}, 32'h210, "page jump");
    chk({24'h0, i_qpfe_mem_model.df[7'h25]}, 32'h5a, "indirect");
    chk({24'h0, i_qpfe_mem_model.df[7'h31]}, 32'hb4, "banked rotate");
    wb(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h0025_384b, "swap and status");
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    @(posedge clk);
    i_qpfe_mem_model.pm[11'h000] = 12'h448;
    i_qpfe_mem_model.pm[11'h001] = 12'h368;
    i_qpfe_mem_model.pm[11'h002] = 12'h048;
    i_qpfe_mem_model.pm[11'h003] = 12'h0a8;
    i_qpfe_mem_model.pm[11'h004] = 12'h810;
    i_qpfe_mem_model.pm[11'h005] = 12'h4ff;
    i_qpfe_mem_model.pm[11'h010] = 12'h810;
    @(posedge clk);
    sys_rst <= 1'b0;
    t_prog();
    t_phases(1'b1);
    t_bus();
    t_ext_reset();
    t_ops();
    results();
  end
endmodule // testbench

`default_nettype wire
